// *** core/irc_pkg.sv ***
// Package of the interrupt request controller: register map, fields, resets.
// Assumes a 25 MHz peripheral clock and an APB master with 32-bit data.
package irc_pkg;
  localparam int NSRC   = 16;  // Peripheral 4, pins 8, software 1, event link 3
  localparam int NPER   = 4;
  localparam int NPIN   = 8;
  localparam int SRC_PIN0 = 4;
  localparam int SRC_SW   = 12;
  localparam int SRC_EL0  = 13;
  localparam int NEL    = 3;
  localparam int PRIW   = 4;
  localparam int IDW    = 4;
  localparam int FILT_LEN = 3;  // Stored samples; these and the current sample, four in all, must agree

  // Byte offsets
  localparam logic [7:0] OFF_PEND  = 8'h00;  // Pending requests, write one clears edges
  localparam logic [7:0] OFF_ENA   = 8'h04;  // Source enables
  localparam logic [7:0] OFF_TRIG  = 8'h08;  // Pin trigger modes, 2 bits per pin
  localparam logic [7:0] OFF_FILT  = 8'h0c;  // Pin filter enables [7:0], nmi filter [8], nmi edge [9]
  localparam logic [7:0] OFF_SWI   = 8'h10;  // Software trigger
  localparam logic [7:0] OFF_FAST  = 8'h14;  // [4] valid, [3:0] source
  localparam logic [7:0] OFF_XFER  = 8'h18;  // Transfer start select [15:0], engine [31:16]
  localparam logic [7:0] OFF_PRI0  = 8'h1c;  // Priorities sources 0-7
  localparam logic [7:0] OFF_PRI1  = 8'h20;  // Priorities sources 8-15
  localparam logic [7:0] OFF_ACT   = 8'h24;  // Presented id [3:0], valid [4], fast [5]
  localparam logic [7:0] OFF_ISTAT = 8'h28;  // Sticky events: [0] nmi, [1] request, [2] wake
  localparam logic [7:0] OFF_IMASK = 8'h2c;
  localparam logic [7:0] OFF_PWR   = 8'h30;  // [0] sleep, [1] standby

  localparam logic [1:0] TRIG_LOW  = 2'h0;
  localparam logic [1:0] TRIG_FALL = 2'h1;
  localparam logic [1:0] TRIG_RISE = 2'h2;
  localparam logic [1:0] TRIG_BOTH = 2'h3;

  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [NPER-1:0] PER_EDGE = 4'h3;  // Sources 0,1 edge; 2,3 level

  typedef struct packed {
    logic [IDW-1:0] id;
    logic           valid;
    logic           fast;
  } irc_req_t;
endpackage : irc_pkg

// *** core/irc_top.sv ***
// Interrupt request controller: source detection, priority, fast and transfer routing.
// Assumes synchronous inputs, an APB master and peripheral requests held as levels.
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module irc_top import irc_pkg::*; (
  input  wire logic            i_clk,      // 25 MHz clock
  input  wire logic            i_rst_n,    // Async reset, active low
  input  wire logic            i_psel,     // APB select
  input  wire logic            i_penable,  // APB enable
  input  wire logic            i_pwrite,   // APB write
  input  wire logic [7:0]      i_paddr,    // APB address
  input  wire logic [31:0]     i_pwdata,   // APB write data
  output logic      [31:0]     o_prdata,   // APB read data
  output logic                 o_pready,   // APB ready
  output logic                 o_pslverr,  // APB error
  input  wire logic [NPER-1:0] i_per_req,  // Peripheral requests
  input  wire logic [NPIN-1:0] i_ext_pin,  // External request pins
  input  wire logic [NEL-1:0]  i_el_evt,   // Event router requests
  input  wire logic            i_nmi_pin,  // Non-maskable pin
  input  wire logic            i_rtc_alarm,// Clock alarm or periodic
  input  wire logic            i_ack,      // Core takes presented request
  output irc_req_t             o_req,      // Request to core
  output logic                 o_nmi,      // Non-maskable request
  output logic [NSRC-1:0]      o_xfer_start, // Transfer unit start pulses
  output logic [NSRC-1:0]      o_dme_start,  // Memory engine start pulses
  output logic                 o_wake,     // Wake from low power
  output logic                 o_irq       // Summary interrupt
);
  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  // Assert at once, release through two stages so no flop sees a runt edge
  logic rst_s1_ff, rst_ff;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_ff <= 1'b0;
      rst_ff    <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_ff    <= rst_s1_ff;
    end
  end
  wire rst_n = rst_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [NSRC-1:0] ena_ff, xsel_ff, dsel_ff, pend_ff;
  logic [15:0]     trig_ff;
  logic [9:0]      filt_ff;
  logic [4:0]      fast_ff;
  logic [31:0]     pri0_ff, pri1_ff;
  logic [2:0]      istat_ff, imask_ff;
  logic [1:0]      pwr_ff;
  logic [31:0]     rdata;

  wire wr      = i_psel && i_penable && i_pwrite;
  wire rd      = i_psel && !i_penable && !i_pwrite;  // Read setup, data fetched here
  wire hit     = (i_paddr <= OFF_PWR) && (i_paddr[1:0] == 2'h0);
  wire wr_pend = wr && i_paddr == OFF_PEND;
  wire wr_swi  = wr && i_paddr == OFF_SWI;
  wire wr_ist  = wr && i_paddr == OFF_ISTAT;

  // Register writes
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ena_ff <= RST_ZERO[NSRC-1:0];
      xsel_ff <= RST_ZERO[NSRC-1:0];
      dsel_ff <= RST_ZERO[NSRC-1:0];
      trig_ff <= RST_ZERO[15:0];
      filt_ff <= RST_ZERO[9:0];
      fast_ff <= RST_ZERO[4:0];
      pri0_ff <= RST_ZERO;
      pri1_ff <= RST_ZERO;
      imask_ff <= RST_ZERO[2:0];
      pwr_ff <= RST_ZERO[1:0];
    end else if (wr) begin
      case (i_paddr)
        OFF_ENA:   ena_ff   <= i_pwdata[NSRC-1:0];
        OFF_TRIG:  trig_ff  <= i_pwdata[15:0];
        OFF_FILT:  filt_ff  <= i_pwdata[9:0];
        OFF_FAST:  fast_ff  <= i_pwdata[4:0];   // single id field
        OFF_XFER: begin
          xsel_ff <= i_pwdata[15:0];
          dsel_ff <= i_pwdata[31:16];
        end
        OFF_PRI0:  pri0_ff  <= i_pwdata;
        OFF_PRI1:  pri1_ff  <= i_pwdata;
        OFF_IMASK: imask_ff <= i_pwdata[2:0];
        OFF_PWR:   pwr_ff   <= i_pwdata[1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin filters and detection, plus nmi on index NPIN
  logic [NPIN:0] filt_q_ff, prev_ff;
  wire  [NPIN:0] raw = {i_nmi_pin, i_ext_pin};
  wire  [NPIN:0] pin_evt;
  genvar g;
  generate
    for (g = 0; g <= NPIN; g++) begin : g_pin
      logic [FILT_LEN-1:0] sh_ff;
      wire all1 = &{sh_ff, raw[g]};
      wire all0 = ~|{sh_ff, raw[g]};
      // Filter takes a level only when it has held for several samples
      // Reset to the idle high level so that release shows no false edge
      always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          sh_ff <= {FILT_LEN{1'b1}};
          filt_q_ff[g] <= 1'b1;
          prev_ff[g] <= 1'b1;
        end else begin
          sh_ff <= {sh_ff[FILT_LEN-2:0], raw[g]};
          if (!filt_ff[g == NPIN ? 8 : g]) filt_q_ff[g] <= raw[g];
          else if (all1) filt_q_ff[g] <= 1'b1;
          else if (all0) filt_q_ff[g] <= 1'b0;
          prev_ff[g] <= filt_q_ff[g];
        end
      end
      wire rise = filt_q_ff[g] && !prev_ff[g];
      wire fall = !filt_q_ff[g] && prev_ff[g];
      if (g < NPIN) begin : g_ext
        wire [1:0] m = trig_ff[2*g+1:2*g];
        assign pin_evt[g] = (m == TRIG_LOW)  ? !filt_q_ff[g] :
                            (m == TRIG_FALL) ? fall :
                            (m == TRIG_RISE) ? rise : (rise | fall);
      end else begin : g_nmi
        // Nmi uses its own edge select, never a level
        assign pin_evt[g] = filt_ff[9] ? rise : fall;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Source requests; level sources follow the input, edge sources latch
  logic [NPER-1:0] per_prev_ff;
  logic            nmi_ff;
  wire  [NSRC-1:0] set_evt = {i_el_evt, wr_swi, pin_evt[NPIN-1:0],
                              i_per_req & ~per_prev_ff};
  wire  [NSRC-1:0] is_lvl;
  assign is_lvl[NPER-1:0] = ~PER_EDGE;
  generate
    for (g = 0; g < NPIN; g++) begin : g_lvl
      assign is_lvl[SRC_PIN0+g] = (trig_ff[2*g+1:2*g] == TRIG_LOW);
    end
  endgenerate
  assign is_lvl[NSRC-1:SRC_SW] = '0;
  wire [NSRC-1:0] lvl_val = {{(NSRC-SRC_PIN0){1'b0}}, i_per_req} |
                            {{(NSRC-SRC_PIN0-NPIN){1'b0}}, pin_evt[NPIN-1:0], 4'h0};

  // Winner-take clear on ack or start; set wins over write-one clear
  wire [NSRC-1:0] take;
  wire [NSRC-1:0] clr = (wr_pend ? i_pwdata[NSRC-1:0] : '0) | take;
  wire [NSRC-1:0] nxt_pend = (is_lvl & lvl_val) | (~is_lvl & ((pend_ff & ~clr) | set_evt));
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_ff <= RST_ZERO[NSRC-1:0];
      per_prev_ff <= RST_ZERO[NPER-1:0];
    end else begin
      pend_ff <= nxt_pend;
      per_prev_ff <= i_per_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Priority search over enabled core-routed sources
  wire [NSRC-1:0] act = pend_ff & ena_ff & ~xsel_ff;
  wire [63:0]     pri_all = {pri1_ff, pri0_ff};
  logic [IDW-1:0]  best_id;
  logic [PRIW-1:0] best_pri;
  logic            best_v;
  always_comb begin
    best_id = '0;
    best_pri = '0;
    best_v = 1'b0;
    for (int i = NSRC-1; i >= 0; i--) begin
      if (act[i] && (!best_v || pri_all[i*PRIW +: PRIW] >= best_pri)) begin
        best_id = IDW'(i);
        best_pri = pri_all[i*PRIW +: PRIW];
        best_v = 1'b1;
      end
    end
  end
  // Independent view of the search: any enabled rival that beats the winner
  wire [NSRC-1:0] outrank;
  for (g = 0; g < NSRC; g++) begin : g_rank
    assign outrank[g] = act[g] && ((pri_all[g*PRIW +: PRIW] > best_pri) ||
                        (pri_all[g*PRIW +: PRIW] == best_pri && IDW'(g) < best_id));
  end

  // A fired start clears an edge source on the next edge, so each routed edge event
  // yields one pulse on whichever engine it selects; a core take and a
  // start may fall in one cycle and both must clear.
  wire [NSRC-1:0] started = o_xfer_start | o_dme_start;
  assign take = ((i_ack && o_req.valid) ? (NSRC'(1) << o_req.id) : '0) | started;

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  wire [NSRC-1:0] xs = pend_ff & ena_ff & xsel_ff & ~started;
  wire wake_std = nmi_ff || |(pend_ff[SRC_PIN0 +: NPIN] & ena_ff[SRC_PIN0 +: NPIN]) || i_rtc_alarm;
  wire wake_slp = nmi_ff || |(pend_ff & ena_ff);
  wire nxt_wake = pwr_ff[1] ? wake_std : pwr_ff[0] ? wake_slp : 1'b0;
  // Sticky status; an event in the cycle of a write-one clear wins
  wire [2:0] nxt_ist = (istat_ff & ~(wr_ist ? i_pwdata[2:0] : 3'h0))
                     | {nxt_wake, best_v, pin_evt[NPIN]};
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_req <= '0;
      o_nmi <= 1'b0;
      nmi_ff <= 1'b0;
      o_xfer_start <= '0;
      o_dme_start <= '0;
      o_wake <= 1'b0;
      istat_ff <= RST_ZERO[2:0];
      o_irq <= 1'b0;
      o_prdata <= RST_ZERO;
    end else begin
      o_req.id <= best_id;
      o_req.valid <= best_v && !(i_ack && o_req.valid);
      o_req.fast <= fast_ff[4] && fast_ff[3:0] == best_id;
      nmi_ff <= pin_evt[NPIN] | (nmi_ff & !(wr_pend && i_pwdata[16]));
      o_nmi <= nmi_ff;
      o_xfer_start <= xs & ~dsel_ff;
      o_dme_start <= xs & dsel_ff;
      o_wake <= nxt_wake;
      istat_ff <= nxt_ist;
      o_irq <= |(nxt_ist & imask_ff);
      o_prdata <= rd ? rdata : RST_ZERO;
    end
  end

  // Read mux, caught into o_prdata at the setup edge so it stands with pready
  always_comb begin
    case (i_paddr)
      OFF_PEND:  rdata = {15'h0, nmi_ff, pend_ff};
      OFF_ENA:   rdata = {16'h0, ena_ff};
      OFF_TRIG:  rdata = {16'h0, trig_ff};
      OFF_FILT:  rdata = {22'h0, filt_ff};
      OFF_FAST:  rdata = {27'h0, fast_ff};
      OFF_XFER:  rdata = {dsel_ff, xsel_ff};
      OFF_PRI0:  rdata = pri0_ff;
      OFF_PRI1:  rdata = pri1_ff;
      OFF_ACT:   rdata = {26'h0, o_req.fast, o_req.valid, o_req.id};
      OFF_ISTAT: rdata = {29'h0, istat_ff};
      OFF_IMASK: rdata = {29'h0, imask_ff};
      OFF_PWR:   rdata = {30'h0, pwr_ff};
      default:   rdata = RST_ZERO;
    endcase
  end

  // Zero-wait slave, error on unmapped address
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !hit;
    end
  end

  // Assertions
  a_fast_match: assert property (@(posedge i_clk) disable iff (!rst_n)
    o_req.fast |-> $past(fast_ff[4]) && $past(fast_ff[3:0]) == o_req.id)
    else $error("fast flag on wrong source");
  a_start_excl: assert property (@(posedge i_clk) disable iff (!rst_n)
    !(|(o_xfer_start & o_dme_start))) else $error("double start");
  a_swi_sets: assert property (@(posedge i_clk) disable iff (!rst_n)
    wr_swi |=> pend_ff[SRC_SW]) else $error("software source not raised");
  a_nmi_flag: assert property (@(posedge i_clk) disable iff (!rst_n)
    pin_evt[NPIN] |-> ##2 o_nmi) else $error("nmi missed");
  a_stby_wake: assert property (@(posedge i_clk) disable iff (!rst_n)
    (pwr_ff[1] && !wake_std) |=> !o_wake) else $error("bad standby wake");
  a_slp_wake: assert property (@(posedge i_clk) disable iff (!rst_n)
    (pwr_ff == 2'h1 && nmi_ff) |=> o_wake) else $error("sleep wake missed");
  a_prio_win: assert property (@(posedge i_clk) disable iff (!rst_n)
    best_v |-> act[best_id]) else $error("winner not pending");
  a_lvl_follow: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_per_req[2] |=> pend_ff[2]) else $error("level source lost");

  // Checks against an independent view of pending, pin level, routing, priority, nmi and wake
  a_edge_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
    (pend_ff[0] && !take[0] && !(wr_pend && i_pwdata[0])) |=> pend_ff[0])
    else $error("edge source lost before clear");
  a_pin_low: assert property (@(posedge i_clk) disable iff (!rst_n)
    (is_lvl[SRC_PIN0] && !filt_q_ff[0]) |=> pend_ff[SRC_PIN0])
    else $error("low level pin not pending");
  a_start_once: assert property (@(posedge i_clk) disable iff (!rst_n)
    (|started) |=> ((started & $past(started)) == '0))
    else $error("start pulse repeated");
  a_xfer_no_core: assert property (@(posedge i_clk) disable iff (!rst_n)
    o_req.valid |-> (($past(xsel_ff) & (NSRC'(1) << o_req.id)) == '0))
    else $error("routed source shown to core");
  a_prio_max: assert property (@(posedge i_clk) disable iff (!rst_n)
    (|act) |-> (best_v && outrank == '0))
    else $error("winner outranked");
  a_nmi_clear: assert property (@(posedge i_clk) disable iff (!rst_n)
    (wr_pend && i_pwdata[16] && !pin_evt[NPIN]) |=> !nmi_ff)
    else $error("nmi not cleared");
  a_nmi_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
    (nmi_ff && !(wr_pend && i_pwdata[16])) |=> nmi_ff)
    else $error("nmi flag dropped");
  a_stby_alarm: assert property (@(posedge i_clk) disable iff (!rst_n)
    (pwr_ff[1] && i_rtc_alarm) |=> o_wake)
    else $error("alarm wake missed");
endmodule : irc_top
`default_nettype wire

// *** tb/irc_core_model.sv ***
// Core-side model: takes each presented request after a set delay.
// Assumes o_req valid drops one edge after the take pulse is seen.
`timescale 1ns/1ps
`default_nettype none
module irc_core_model import irc_pkg::*; (
  input  wire logic       i_clk,    // Clock
  input  wire logic       i_rst_n,  // Reset, active low
  input  wire logic [7:0] i_dly,    // Cycles before taking
  input  wire irc_req_t   i_req,    // Presented request
  output logic            o_ack     // Take pulse
);
  logic [7:0] cnt_ff;
  logic       hold_ff;
  ////////////////////////////////////////////////////////////////////////////////
  // One take pulse per request, then wait until valid drops
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff  <= 8'h00;
      hold_ff <= 1'b0;
      o_ack   <= 1'b0;
    end else begin
      o_ack <= 1'b0;
      if (!i_req.valid) begin
        cnt_ff  <= 8'h00;
        hold_ff <= 1'b0;
      end else if (!hold_ff && !o_ack && cnt_ff >= i_dly) begin
        o_ack   <= 1'b1;
        hold_ff <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end
endmodule : irc_core_model
`default_nettype wire

// *** tb/testbench.sv ***
// Bench of the interrupt request controller: APB driver, core model, queued checks.
// Assumes zero-wait APB and the offsets and fields of the package.
`timescale 1ns/1ps
`default_nettype none
module testbench import irc_pkg::*;;
  logic clk, rst_n, psel, penable, pwrite, nmi, ack, pready, slverr, wake, irq, onmi, alarm;
  logic [7:0] paddr, dly, pin;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] per, p;
  logic [2:0] el;
  logic [NSRC-1:0] xs, ds;
  irc_req_t req;
  logic [32:0] rq[$];
  logic [4:0] gq[$];
  int fail_count, n_checks;
  irc_top dut (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(slverr), .i_per_req(per), .i_ext_pin(pin),
    .i_el_evt(el), .i_nmi_pin(nmi), .i_rtc_alarm(alarm), .i_ack(ack), .o_req(req),
    .o_nmi(onmi), .o_xfer_start(xs), .o_dme_start(ds), .o_wake(wake), .o_irq(irq));
  irc_core_model core (.i_clk(clk), .i_rst_n(rst_n), .i_dly(dly), .i_req(req), .o_ack(ack));
  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  // Report, compare and closing tasks
  task summarize;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task cmp(input logic [32:0] e, input logic [32:0] g);
    n_checks++;
    if (e !== g) begin
      fail_count++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask : cmp
  task timeout;
    fail_count++;
    summarize();
  endtask : timeout
  // APB transfer: hold the request until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) timeout();
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [7:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  function automatic logic pick(input int s);
    case (s)
      0: pick = xs[SRC_SW];
      1: pick = ds[SRC_SW];
      2: pick = wake;
      3: pick = onmi;
      default: pick = irq;
    endcase
  endfunction : pick
  // Wait a bounded time for an output level, then compare
  task wt(input int s, input logic e);
    int n;
    n = 0;
    while (pick(s) !== e && n < 20) begin @(posedge clk); n++; end
    cmp({32'h0, e}, {32'h0, pick(s)});
  endtask : wt
  task drain;
    int n;
    n = 0;
    while (gq.size() > 0 && n < 300) begin @(posedge clk); n++; end
    if (gq.size() > 0) timeout();
  endtask : drain
  ////////////////////////////////////////////////////////////////////////////////
  // Watcher: read data and taken requests against the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      cmp(rq.size() ? rq.pop_front() : 33'h1_dead_beef, {slverr, prdata});
    if (ack && req.valid === 1'b1)
      cmp(gq.size() ? {28'h0, gq.pop_front()} : 33'h1_0000_0000, {28'h0, req.fast, req.id});
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {clk, rst_n, psel, penable, pwrite, alarm, per, el, paddr, pwdata} = '0;
    pin = 8'hff;
    nmi = 1'b1;  // Idle high, as the pin filter resets
    dly = 8'h08;
    fail_count = 0;
    n_checks = 0;
    r = $urandom(86152);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(OFF_ENA, 33'h0);
    rd(8'hfc, 33'h1_0000_0000);
    r = $urandom;
    apb(1'b1, OFF_PRI0, r);
    rd(OFF_PRI0, {1'b0, r});
    per <= 4'h5;
    repeat (4) @(posedge clk);
    apb(1'b1, OFF_PEND, 32'h0000_000f);
    rd(OFF_PEND, 33'h4);
    per <= 4'h0;
    apb(1'b1, OFF_TRIG, 32'h0000_00e4);
    pin <= 8'hf0;
    repeat (4) @(posedge clk);
    rd(OFF_PEND, 33'hb0);
    apb(1'b1, OFF_PEND, 32'h0000_ffff);
    pin <= 8'hff;
    repeat (4) @(posedge clk);
    rd(OFF_PEND, 33'hc0);
    apb(1'b1, OFF_PEND, 32'h0000_ffff);
    p = 4'($urandom_range(15, 1));
    apb(1'b1, OFF_PRI0, {8{p}});
    apb(1'b1, OFF_PRI1, {8{p}});
    apb(1'b1, OFF_SWI, 32'h1);
    el <= 3'h7;
    @(posedge clk);
    el <= 3'h0;
    repeat (4) @(posedge clk);
    for (int i = 12; i < 16; i++) gq.push_back(5'(i));
    apb(1'b1, OFF_ENA, 32'h0000_f000);
    drain();
    dly <= 8'h00;
    apb(1'b1, OFF_FAST, 32'h0000_001c);
    gq.push_back(5'h1c);
    apb(1'b1, OFF_SWI, 32'h1);
    drain();
    apb(1'b1, OFF_FAST, 32'h0);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, OFF_XFER, k ? 32'h1000_1000 : 32'h0000_1000);
      apb(1'b1, OFF_SWI, 32'h1);
      wt(k, 1'b1);
    end
    apb(1'b1, OFF_XFER, 32'h0);
    apb(1'b1, OFF_PWR, 32'h1);
    gq.push_back(5'h0c);
    apb(1'b1, OFF_SWI, 32'h1);
    wt(2, 1'b1);
    drain();
    apb(1'b1, OFF_PWR, 32'h2);
    gq.push_back(5'h0c);
    apb(1'b1, OFF_SWI, 32'h1);
    repeat (3) @(posedge clk);
    cmp(33'h0, {32'h0, wake});
    drain();
    alarm <= 1'b1;
    wt(2, 1'b1);
    alarm <= 1'b0;
    apb(1'b1, OFF_PWR, 32'h0);
    apb(1'b1, OFF_FILT, 32'h0000_0200);
    nmi <= 1'b0;
    repeat (6) @(posedge clk);
    wt(3, 1'b0);
    nmi <= 1'b1;
    wt(3, 1'b1);
    apb(1'b1, OFF_PEND, 32'h0001_0000);
    wt(3, 1'b0);
    apb(1'b1, OFF_FILT, 32'h0000_0300);
    nmi <= 1'b0;
    @(posedge clk);
    nmi <= 1'b1;
    repeat (8) @(posedge clk);
    wt(3, 1'b0);
    nmi <= 1'b0;
    repeat (6) @(posedge clk);
    nmi <= 1'b1;
    wt(3, 1'b1);
    apb(1'b1, OFF_IMASK, 32'h0);
    wt(4, 1'b0);
    apb(1'b1, OFF_IMASK, 32'h1);
    wt(4, 1'b1);
    apb(1'b1, OFF_ISTAT, 32'h7);
    wt(4, 1'b0);
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule : testbench
`default_nettype wire
